/* File: asrc_pkg.sv */
// What this block and its host do
// [R1] Internal-clock mode: new bit presented after each serial clock fall.
// [R2] Previous bit stays valid for the hold interval after each fall.
// [R3] Host returns serial clock low once a word has been transferred.
// [R4] External-clock mode: serial clock shifts bits and times conversion.
// [R5] Sixteen bits per transfer: four zeros, then 12-bit result, MSB first.
// [R6] After sixteenth falling edge, hold last bit then release output.
// [R7] The 12-bit result is two's complement coded.
// [R8] Internal mode: select acts on edges; its fall holds and converts.
// [R9] External mode: select is an active-low chip select framing the word.
// [R10] External mode: host leaves a minimum quiet time between conversions.
// [R11] Internal mode: host waits for conversion end before clocking out.
// [R12] Serial output stays high impedance while no transfer is in progress.
package asrc_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int HOLD_TIME_PS = 20000;
	// Least time: round up
	localparam int HOLD_CYCLES =
		(HOLD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONVERT_TIME_NS = 3300;
	// Longest time: round down
	localparam int CONVERT_CYCLES = (CONVERT_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int QUIET_TIME_NS = 100;
	localparam int QUIET_CYCLES =
		(QUIET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESULT_BITS = 12;
	localparam int WORD_BITS = 16;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;

	typedef enum logic {
		ASRC_MODE_INTERNAL,
		ASRC_MODE_EXTERNAL
	} asrc_mode_type;

	typedef struct packed {
		logic data;
		logic oe;
	} asrc_pin_type;
endpackage

/* File: asrc_top.sv */
`timescale 1ns/1ps
module asrc_top
	import asrc_pkg::*;
#(
	parameter int CONV_CYCLES = CONVERT_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Mode and sample source
	input wire asrc_mode_type mode,
	input wire logic [RESULT_BITS-1:0] sample_in,
	// Host link pins
	input wire logic select_or_convert_n,
	input wire logic serial_clk,
	output asrc_pin_type serial_result_out,
	// Status
	output logic busy,
	output logic convert_start_edge
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] sel_sync_reg;
	logic [1:0] sck_sync_reg;
	logic sel_last_reg;
	logic sck_last_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sel_sync_reg <= 2'h3;
			sck_sync_reg <= 2'h0;
			sel_last_reg <= 1'h1;
			sck_last_reg <= 1'h0;
		end else begin
			sel_sync_reg <= {sel_sync_reg[0], select_or_convert_n};
			sck_sync_reg <= {sck_sync_reg[0], serial_clk};
			sel_last_reg <= sel_sync_reg[1];
			sck_last_reg <= sck_sync_reg[1];
		end
	end

	logic sel_fall;
	logic sck_fall;
	assign sel_fall = sel_last_reg & ~sel_sync_reg[1];
	assign sck_fall = sck_last_reg & ~sck_sync_reg[1];
	assign convert_start_edge = sel_fall; // R8

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_SHIFT,
		ST_RELEASE
	} asrc_state_type;

	asrc_state_type state_reg;
	logic [15:0] conv_cnt_reg;
	logic [4:0] edge_cnt_reg;
	logic [3:0] hold_cnt_reg;
	logic [WORD_BITS-1:0] shift_reg;
	logic start_go;
	logic abort_go;
	logic shift_go;
	logic last_fall;
	logic conv_done;
	logic hold_done;

	// ----------------------------------------
	// Strobes
	// ----------------------------------------
	// A fall of select while busy is ignored in either mode
	assign start_go = sel_fall && (state_reg == ST_IDLE); // R8 R9
	// Raising select mid-word ends the frame in external mode only
	assign abort_go = (mode == ASRC_MODE_EXTERNAL) && sel_sync_reg[1] &&
		(state_reg == ST_SHIFT); // R9
	// Falls outside a word neither shift nor count
	assign shift_go = sck_fall && (state_reg == ST_SHIFT); // R1 R4
	assign last_fall = shift_go &&
		(edge_cnt_reg == 5'(WORD_BITS - 1)); // R5 R6
	assign conv_done = (conv_cnt_reg == 16'(CONV_CYCLES - 1)); // R11
	assign hold_done = (hold_cnt_reg == 4'(HOLD_CYCLES - 1)); // R6

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	// Sample held at the start edge; the converter core is outside
	// this block, so the held sample stands in for its result.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			shift_reg <= 16'h0000;
		end else if (start_go) begin // R8 R9
			shift_reg <= {LEAD_ZEROS, sample_in}; // R5 R7
		end else if (shift_go) begin
			shift_reg <= {shift_reg[WORD_BITS-2:0], 1'h0}; // R1
		end
	end

	// ----------------------------------------
	// Transfer sequencing
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (start_go) begin // R8 R9
					// External mode converts while the word shifts out
					state_reg <= (mode == ASRC_MODE_INTERNAL) ?
						ST_CONVERT : ST_SHIFT; // R4
				end
			end
			ST_CONVERT: begin
				// Falls of the serial clock are ignored until done
				if (conv_done) begin // R11
					state_reg <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// Abort outranks a fall seen in the same cycle
				if (abort_go) begin
					state_reg <= ST_IDLE; // R9
				end else if (last_fall) begin
					state_reg <= ST_RELEASE; // R6
				end
			end
			ST_RELEASE: begin
				if (hold_done) begin
					state_reg <= ST_IDLE; // R6
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	// Stands in for the internal oscillator; cleared outside conversion
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			conv_cnt_reg <= 16'h0000;
		end else if (state_reg != ST_CONVERT) begin
			conv_cnt_reg <= 16'h0000;
		end else if (!conv_done) begin
			conv_cnt_reg <= conv_cnt_reg + 16'h0001; // R11
		end
	end

	// External mode needs no timer: the sixteen falls time the conversion
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			edge_cnt_reg <= 5'h00;
		end else if (start_go) begin
			edge_cnt_reg <= 5'h00;
		end else if (shift_go) begin
			edge_cnt_reg <= edge_cnt_reg + 5'h01; // R4 R5
		end
	end

	// Measured from the last fall, so the final bit keeps its hold time
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hold_cnt_reg <= 4'h0;
		end else if (state_reg != ST_RELEASE) begin
			hold_cnt_reg <= 4'h0;
		end else if (!hold_done) begin
			hold_cnt_reg <= hold_cnt_reg + 4'h1; // R6
		end
	end

	// ----------------------------------------
	// Output pin with hold after each fall
	// ----------------------------------------
	// Bit changes are delayed by the hold interval so the host may
	// sample on the same falling edge it uses to advance the word.
	logic [3:0] bit_hold_reg;
	logic out_data_reg;
	logic out_oe_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bit_hold_reg <= 4'h0;
		end else if (shift_go) begin
			bit_hold_reg <= 4'(HOLD_CYCLES); // R2
		end else if (bit_hold_reg != 4'h0) begin
			bit_hold_reg <= bit_hold_reg - 4'h1;
		end
	end

	// Only the shifting state moves the pin, so the last bit stays put
	// through the release hold
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_data_reg <= 1'h0;
		end else if (state_reg == ST_SHIFT && bit_hold_reg == 4'h0) begin
			out_data_reg <= shift_reg[WORD_BITS-1]; // R1 R5
		end
	end

	// Enable trails the state by a cycle, in step with the data pin
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_oe_reg <= 1'h0;
		end else begin
			out_oe_reg <= (state_reg == ST_SHIFT) ||
				(state_reg == ST_RELEASE); // R6 R12
		end
	end

	assign serial_result_out.data = out_data_reg;
	assign serial_result_out.oe = out_oe_reg;
	assign busy = (state_reg != ST_IDLE);
endmodule

/* File: asrc_checker.sv */
`timescale 1ns/1ps
module asrc_checker
	import asrc_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Pins
	input wire asrc_mode_type mode,
	input wire logic select_or_convert_n,
	input wire logic serial_clk,
	input wire asrc_pin_type serial_result_out,
	input wire logic busy,
	input wire logic convert_start_edge
);
	wire oe = serial_result_out.oe;
	wire dq = serial_result_out.data;
	wire ext = mode == ASRC_MODE_EXTERNAL;
	wire go = convert_start_edge && !busy;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	idle_hiz_a: assert property (!busy [*2] |-> !oe)
		else $error("idle");
	pulse_one_a: assert property (go |=> !convert_start_edge)
		else $error("pulse");
	start_busy_a: assert property (go |=> busy)
		else $error("start");
	int_wait_a: assert property (go && !ext |=> !oe [*8])
		else $error("early");
	ext_oe_a: assert property (go && ext |-> ##[1:3] oe)
		else $error("drive");
	ext_abort_a: assert property (ext && select_or_convert_n [*6] |-> !oe)
		else $error("abort");
	hold_bit_a: assert property (
		$fell(serial_clk) && oe |=> $stable(dq) [*4])
		else $error("hold");
	lead_zero_a: assert property ($rose(oe) |-> !dq)
		else $error("lead");
	cover property (go && ext);
	cover property (go && !ext);
	cover property ($fell(oe));
endmodule
bind asrc_top asrc_checker asrc_checker_inst (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.mode(mode),
	.select_or_convert_n(select_or_convert_n),
	.serial_clk(serial_clk),
	.serial_result_out(serial_result_out),
	.busy(busy),
	.convert_start_edge(convert_start_edge)
);

/* File: asrc_host_model.sv */
`timescale 1ns/1ps
module asrc_host_model
	import asrc_pkg::*;
(
	// Host pins
	output logic select_or_convert_n = 1'b1,
	output logic serial_clk = 1'b0,
	input wire asrc_pin_type serial_result_out
);
	// Released line reads inverted, never as held data
	wire lvl = serial_result_out.data ^ !serial_result_out.oe;
	task automatic xfer(input bit ext, input int n, output logic [15:0] w);
		select_or_convert_n = 1'b0;
		#70;
		if (!ext) begin
			select_or_convert_n = 1'b1;
			#200;
		end
		for (int i = 0; i < n; i++) begin
			serial_clk = 1'b1;
			#32 serial_clk = 1'b0;
			// Captured on the fall itself, relying on the hold time
			w = {w[14:0], lvl};
			#32;
		end
		#60 select_or_convert_n = 1'b1;
		#200;
	endtask
endmodule

/* File: asrc_tb.sv */
`timescale 1ns/1ps
module testbench;
	import asrc_pkg::*;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	asrc_mode_type mode = ASRC_MODE_INTERNAL;
	logic [RESULT_BITS-1:0] sample_in = 12'h000;
	logic select_or_convert_n, serial_clk, busy, convert_start_edge;
	asrc_pin_type serial_result_out;
	logic [15:0] w;
	int failures = 0, compares = 0;
	asrc_top #(
		.CONV_CYCLES(20)
	) asrc_top_inst (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.mode(mode),
		.sample_in(sample_in),
		.select_or_convert_n(select_or_convert_n),
		.serial_clk(serial_clk),
		.serial_result_out(serial_result_out),
		.busy(busy),
		.convert_start_edge(convert_start_edge)
	);
	asrc_host_model asrc_host_model_inst (
		.select_or_convert_n(select_or_convert_n),
		.serial_clk(serial_clk),
		.serial_result_out(serial_result_out)
	);
	initial forever #2.5 ref_clk = !ref_clk;
	task automatic chk(input string n, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic word(input asrc_mode_type m, input logic [11:0] s);
		@(negedge ref_clk);
		mode = m;
		sample_in = s;
		asrc_host_model_inst.xfer(m, 16, w);
		chk("word", {LEAD_ZEROS, s}, w);
		chk("oe", 16'h0000, 16'(serial_result_out.oe));
	endtask
	task automatic t_int;
		word(ASRC_MODE_INTERNAL, 12'h800);
		word(ASRC_MODE_INTERNAL, 12'h7ff);
		$display("internal end");
	endtask
	task automatic t_ext;
		word(ASRC_MODE_EXTERNAL, 12'h5a3);
		$display("external end");
	endtask
	task automatic t_abort;
		asrc_host_model_inst.xfer(1'b1, 4, w);
		chk("abort", 16'h0000, 16'(serial_result_out.oe));
		$display("abort end");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		t_int();
		t_ext();
		t_abort();
		tally_and_finish();
	end
	initial begin
		#20000;
		failures++;
		tally_and_finish();
	end
endmodule
